// ==== core/hrd_defines.svh ====
// constants for the harmonic restraint decision block
`ifndef HRD_DEFINES_SVH
`define HRD_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HRD_CTRL_OFS 8'h00
`define HRD_RATIO_OFS 8'h04
`define HRD_XLIMIT_OFS 8'h08
`define HRD_STATUS_OFS 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define HRD_CTRL_XEN_BIT 0
`define HRD_CTRL_SIXTY_BIT 1
`define HRD_RATIO2_LSB 0
`define HRD_RATIO5_LSB 8

// ----------------------------------------
// reset values and setting ranges
// ----------------------------------------
`define HRD_XEN_RST 1'b1
`define HRD_SIXTY_RST 1'b0
`define HRD_RATIO2_RST 6'h0F
`define HRD_RATIO5_RST 6'h19
`define HRD_RATIO_MIN 6'h05
`define HRD_RATIO_MAX 6'h32
`define HRD_XLIMIT_RST 16'h1388
`define HRD_XLIMIT_MIN 16'h0064
`define HRD_XLIMIT_MAX 16'hEA60

// ----------------------------------------
// thresholds
// ----------------------------------------
`define HRD_PCT_FULL 7'h64
`define HRD_INRUSH_CUR_DIV 7'h32
`define HRD_EXT_CUR_DIV 7'h0A
`define HRD_EXT_ANGLE_DEG 8'h4B

// ----------------------------------------
// timing
// ----------------------------------------
`define HRD_CLK_NS 5
`define HRD_TICK_US 10
`define HRD_TICK_CYC (`HRD_TICK_US * 1000 / `HRD_CLK_NS)
`define HRD_TICKS_PER_MS (1000 / `HRD_TICK_US)
`define HRD_PICKUP50_US 25000
`define HRD_PICKUP60_US 20830
`define HRD_DROP50_US 15000
`define HRD_DROP60_US 12500
`define HRD_INRUSH50_US 5000000
`define HRD_INRUSH60_US 4166670
`define HRD_LEAST_TICKS(us) (((us) + `HRD_TICK_US - 1) / `HRD_TICK_US)

`endif

// ==== core/hrd_pkg.sv ====
// types for the harmonic restraint decision block
package hrd_pkg;
  typedef logic [2:0] hrd_phase_vec_type;
  typedef logic [5:0] hrd_pct_type;
  typedef enum logic {
    HRD_FREQ_50 = 1'b0,
    HRD_FREQ_60 = 1'b1
  } hrd_freq_type;
endpackage : hrd_pkg

// ==== core/hrd_restraint.sv ====
// per-phase second and fifth harmonic restraint decision with cross blocking
// Operation
// [RULE1] per phase, second harmonic over fundamental above its setting flags high content
// [RULE2] per phase, fifth harmonic over fundamental above its setting flags high content
// [RULE3] flags rise at once; after 25 ms continuous, fall is delayed 15 ms
// [RULE4] cross blocking off: each phase blocked only by its own harmonics
// [RULE5] cross blocking on: any harmonic-blocked phase blocks all three phases
// [RULE6] cross blocking ends after time limit; high phases keep blocking themselves
// [RULE7] three outputs show high second harmonic per phase
// [RULE8] three second harmonic restraints, active with inrush or external fault
// [RULE9] combined second harmonic restraint is OR of the three phases
// [RULE10] three fifth harmonic restraints, one per phase
// [RULE11] combined fifth harmonic restraint is OR of the three phases
// [RULE12] ratio settings in percent, 5 to 50, defaults 15 and 25
// [RULE13] inrush condition kept; second harmonic inrush restraint only while active
// [RULE14] inrush clears after 5 s of current above 2% with no second harmonic
// [RULE15] second harmonic restraint needs inrush or external fault condition
// [RULE16] external fault when two sides differ by at least 75 degrees
// [RULE17] angle check valid only when both side magnitudes exceed 10% rated
// [RULE18] cross blocking enabled by default, limited by its timer
// [RULE19] inrush reasserts and restarts its timer when conditions fail
// [RULE20] frequency setting selects 50 Hz or 60 Hz timer constants
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "hrd_defines.svh"

module hrd_restraint #(
  parameter int AMP_W = 16,
  parameter int TICK_CYC = `HRD_TICK_CYC,
  parameter int INRUSH50_TICKS = `HRD_INRUSH50_US / `HRD_TICK_US,
  parameter int INRUSH60_TICKS = `HRD_INRUSH60_US / `HRD_TICK_US
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // harmonic amplitudes per phase
  input wire logic [AMP_W-1:0] fundamental_amp_ph1_i,
  input wire logic [AMP_W-1:0] fundamental_amp_ph2_i,
  input wire logic [AMP_W-1:0] fundamental_amp_ph3_i,
  input wire logic [AMP_W-1:0] second_harm_amp_ph1_i,
  input wire logic [AMP_W-1:0] second_harm_amp_ph2_i,
  input wire logic [AMP_W-1:0] second_harm_amp_ph3_i,
  input wire logic [AMP_W-1:0] fifth_harm_amp_ph1_i,
  input wire logic [AMP_W-1:0] fifth_harm_amp_ph2_i,
  input wire logic [AMP_W-1:0] fifth_harm_amp_ph3_i,
  // compensated side currents and angle difference
  input wire logic [AMP_W-1:0] rated_current_i,
  input wire logic [AMP_W-1:0] side1_mag_ph1_i,
  input wire logic [AMP_W-1:0] side1_mag_ph2_i,
  input wire logic [AMP_W-1:0] side1_mag_ph3_i,
  input wire logic [AMP_W-1:0] side2_mag_ph1_i,
  input wire logic [AMP_W-1:0] side2_mag_ph2_i,
  input wire logic [AMP_W-1:0] side2_mag_ph3_i,
  input wire logic [7:0] angle_diff_ph1_i,
  input wire logic [7:0] angle_diff_ph2_i,
  input wire logic [7:0] angle_diff_ph3_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // restraint flags
  output logic second_harm_high_ph1_o,
  output logic second_harm_high_ph2_o,
  output logic second_harm_high_ph3_o,
  output logic second_harm_restraint_ph1_o,
  output logic second_harm_restraint_ph2_o,
  output logic second_harm_restraint_ph3_o,
  output logic second_harm_restraint_any_o,
  output logic fifth_harm_restraint_ph1_o,
  output logic fifth_harm_restraint_ph2_o,
  output logic fifth_harm_restraint_ph3_o,
  output logic fifth_harm_restraint_any_o,
  // blocking towards trip logic
  output logic phase_block_ph1_o,
  output logic phase_block_ph2_o,
  output logic phase_block_ph3_o,
  output logic cross_block_active_o,
  output logic inrush_condition_o,
  output logic ext_fault_condition_o
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic ratio_high(input logic [AMP_W-1:0] harm,
                                      input logic [AMP_W-1:0] fund,
                                      input hrd_pkg::hrd_pct_type pct);
    logic [AMP_W+6:0] lhs;
    logic [AMP_W+6:0] rhs;
    lhs = (AMP_W+7)'(harm) * (AMP_W+7)'(`HRD_PCT_FULL);
    rhs = (AMP_W+7)'(fund) * (AMP_W+7)'(pct);
    ratio_high = lhs > rhs;
  endfunction : ratio_high

  // true when mag exceeds rated divided by div
  function automatic logic above_share(input logic [AMP_W-1:0] mag,
                                       input logic [AMP_W-1:0] rated,
                                       input logic [6:0] div);
    logic [AMP_W+6:0] scaled;
    scaled = (AMP_W+7)'(mag) * (AMP_W+7)'(div);
    above_share = scaled > (AMP_W+7)'(rated);
  endfunction : above_share

  function automatic hrd_pkg::hrd_pct_type clamp_pct(input hrd_pkg::hrd_pct_type v);
    if (v < `HRD_RATIO_MIN) begin
      clamp_pct = `HRD_RATIO_MIN;
    end else if (v > `HRD_RATIO_MAX) begin
      clamp_pct = `HRD_RATIO_MAX;
    end else begin
      clamp_pct = v;
    end
  endfunction : clamp_pct

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic xen_reg;
  hrd_pkg::hrd_freq_type freq_reg;
  hrd_pkg::hrd_pct_type ratio2_reg;
  hrd_pkg::hrd_pct_type ratio5_reg;
  logic [15:0] xlimit_reg;
  logic [31:0] status;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xen_reg <= `HRD_XEN_RST; // see [RULE18]
      freq_reg <= hrd_pkg::HRD_FREQ_50;
      ratio2_reg <= `HRD_RATIO2_RST; // see [RULE12]
      ratio5_reg <= `HRD_RATIO5_RST;
      xlimit_reg <= `HRD_XLIMIT_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `HRD_CTRL_OFS: begin
          xen_reg <= reg_wdata_i[`HRD_CTRL_XEN_BIT];
          freq_reg <= hrd_pkg::hrd_freq_type'(reg_wdata_i[`HRD_CTRL_SIXTY_BIT]);
        end
        `HRD_RATIO_OFS: begin
          // out-of-range writes are clamped so the compare never sees them
          ratio2_reg <= clamp_pct(reg_wdata_i[`HRD_RATIO2_LSB+:6]); // see [RULE12]
          ratio5_reg <= clamp_pct(reg_wdata_i[`HRD_RATIO5_LSB+:6]);
        end
        `HRD_XLIMIT_OFS: begin
          if (reg_wdata_i[15:0] < `HRD_XLIMIT_MIN) begin
            xlimit_reg <= `HRD_XLIMIT_MIN;
          end else if (reg_wdata_i[15:0] > `HRD_XLIMIT_MAX) begin
            xlimit_reg <= `HRD_XLIMIT_MAX;
          end else begin
            xlimit_reg <= reg_wdata_i[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `HRD_CTRL_OFS: reg_rdata_o <= {30'h0, freq_reg, xen_reg};
        `HRD_RATIO_OFS: reg_rdata_o <= {18'h0, ratio5_reg, 2'h0, ratio2_reg};
        `HRD_XLIMIT_OFS: reg_rdata_o <= {16'h0, xlimit_reg};
        `HRD_STATUS_OFS: reg_rdata_o <= status;
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // time base and frequency selection
  // ----------------------------------------
  logic [11:0] div_reg;
  logic tick_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 12'h0;
      tick_reg <= 1'b0;
    end else if (div_reg == 12'(TICK_CYC - 1)) begin
      div_reg <= 12'h0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 12'h1;
      tick_reg <= 1'b0;
    end
  end

  logic sixty;
  logic [11:0] pickup_ticks;
  logic [11:0] drop_ticks;
  logic [18:0] inrush_ticks;
  assign sixty = (freq_reg == hrd_pkg::HRD_FREQ_60);
  assign pickup_ticks = sixty ? 12'(`HRD_LEAST_TICKS(`HRD_PICKUP60_US)) :
                                12'(`HRD_LEAST_TICKS(`HRD_PICKUP50_US)); // see [RULE20]
  assign drop_ticks = sixty ? 12'(`HRD_LEAST_TICKS(`HRD_DROP60_US)) :
                              12'(`HRD_LEAST_TICKS(`HRD_DROP50_US)); // see [RULE20]
  assign inrush_ticks = sixty ? 19'(INRUSH60_TICKS) : 19'(INRUSH50_TICKS); // see [RULE20]

  // ----------------------------------------
  // ratio detection
  // ----------------------------------------
  logic [AMP_W-1:0] fund [3];
  logic [AMP_W-1:0] h2 [3];
  logic [AMP_W-1:0] h5 [3];
  logic [AMP_W-1:0] s1 [3];
  logic [AMP_W-1:0] s2 [3];
  logic [7:0] ang [3];
  assign fund = '{fundamental_amp_ph1_i, fundamental_amp_ph2_i, fundamental_amp_ph3_i};
  assign h2 = '{second_harm_amp_ph1_i, second_harm_amp_ph2_i, second_harm_amp_ph3_i};
  assign h5 = '{fifth_harm_amp_ph1_i, fifth_harm_amp_ph2_i, fifth_harm_amp_ph3_i};
  assign s1 = '{side1_mag_ph1_i, side1_mag_ph2_i, side1_mag_ph3_i};
  assign s2 = '{side2_mag_ph1_i, side2_mag_ph2_i, side2_mag_ph3_i};
  assign ang = '{angle_diff_ph1_i, angle_diff_ph2_i, angle_diff_ph3_i};

  // flags 0..2 second harmonic, 3..5 fifth harmonic
  logic [5:0] raw;
  logic [2:0] ext_ph;
  logic [2:0] cur_ph;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      raw[p] = ratio_high(h2[p], fund[p], ratio2_reg); // see [RULE1]
      raw[p+3] = ratio_high(h5[p], fund[p], ratio5_reg); // see [RULE2]
      ext_ph[p] = above_share(s1[p], rated_current_i, `HRD_EXT_CUR_DIV) &&
                  above_share(s2[p], rated_current_i, `HRD_EXT_CUR_DIV) && // see [RULE17]
                  (ang[p] >= `HRD_EXT_ANGLE_DEG); // see [RULE16]
      cur_ph[p] = above_share(s1[p], rated_current_i, `HRD_INRUSH_CUR_DIV) ||
                  above_share(s2[p], rated_current_i, `HRD_INRUSH_CUR_DIV);
    end
  end

  // ----------------------------------------
  // pick-up and drop-off extension
  // ----------------------------------------
  logic [11:0] on_cnt_reg [6];
  logic [11:0] drop_cnt_reg [6];
  logic [5:0] armed_reg;
  logic [5:0] stretched;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        on_cnt_reg[i] <= 12'h0;
        drop_cnt_reg[i] <= 12'h0;
      end
      armed_reg <= 6'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        // one extra tick so a partial first tick never shortens the pick-up
        if (!raw[i]) begin
          on_cnt_reg[i] <= 12'h0;
          armed_reg[i] <= 1'b0;
        end else if (tick_reg && !armed_reg[i]) begin
          if (on_cnt_reg[i] == pickup_ticks) begin
            armed_reg[i] <= 1'b1; // see [RULE3]
          end else begin
            on_cnt_reg[i] <= on_cnt_reg[i] + 12'h1;
          end
        end
        if (raw[i]) begin
          drop_cnt_reg[i] <= 12'h0;
        end else if (armed_reg[i]) begin
          drop_cnt_reg[i] <= drop_ticks; // see [RULE3]
        end else if (tick_reg && drop_cnt_reg[i] != 12'h0) begin
          drop_cnt_reg[i] <= drop_cnt_reg[i] - 12'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      stretched[i] = raw[i] || armed_reg[i] || (drop_cnt_reg[i] != 12'h0); // see [RULE3]
    end
  end

  // ----------------------------------------
  // inrush and external fault conditions
  // ----------------------------------------
  logic inrush_reg;
  logic ext_reg;
  logic [18:0] inrush_cnt_reg;
  logic inrush_qual;
  assign inrush_qual = (|cur_ph) && !(|stretched[2:0]);
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      inrush_reg <= 1'b1;
      inrush_cnt_reg <= 19'h0;
      ext_reg <= 1'b0;
    end else begin
      ext_reg <= |ext_ph; // see [RULE16]
      if (!inrush_qual) begin
        inrush_reg <= 1'b1; // see [RULE19]
        inrush_cnt_reg <= 19'h0;
      end else if (tick_reg && inrush_reg) begin
        if (inrush_cnt_reg == inrush_ticks) begin
          inrush_reg <= 1'b0; // see [RULE14]
        end else begin
          inrush_cnt_reg <= inrush_cnt_reg + 19'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // restraint flags and cross blocking
  // ----------------------------------------
  hrd_pkg::hrd_phase_vec_type high2_reg;
  hrd_pkg::hrd_phase_vec_type r2_reg;
  hrd_pkg::hrd_phase_vec_type r5_reg;
  hrd_pkg::hrd_phase_vec_type block_reg;
  hrd_pkg::hrd_phase_vec_type r2_next;
  hrd_pkg::hrd_phase_vec_type own_next;
  logic r2_any_reg;
  logic r5_any_reg;
  logic cross_reg;
  logic [22:0] xcnt_reg;
  logic [22:0] xlimit_ticks;
  logic cross_next;
  assign r2_next = stretched[2:0] & {3{inrush_reg || ext_reg}}; // see [RULE13] see [RULE15]
  assign own_next = r2_next | stretched[5:3];
  assign xlimit_ticks = 23'(xlimit_reg) * 23'(`HRD_TICKS_PER_MS);
  // a later block event after timeout does not restart the window until all clear
  assign cross_next = xen_reg && (|own_next) && (xcnt_reg < xlimit_ticks); // see [RULE6]
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xcnt_reg <= 23'h0;
    end else if (!xen_reg || !(|own_next)) begin
      xcnt_reg <= 23'h0;
    end else if (tick_reg && xcnt_reg < xlimit_ticks) begin
      xcnt_reg <= xcnt_reg + 23'h1; // see [RULE6]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high2_reg <= 3'h0;
      r2_reg <= 3'h0;
      r5_reg <= 3'h0;
      r2_any_reg <= 1'b0;
      r5_any_reg <= 1'b0;
      block_reg <= 3'h0;
      cross_reg <= 1'b0;
    end else begin
      high2_reg <= stretched[2:0]; // see [RULE7]
      r2_reg <= r2_next; // see [RULE8]
      r5_reg <= stretched[5:3]; // see [RULE10]
      r2_any_reg <= |r2_next; // see [RULE9]
      r5_any_reg <= |stretched[5:3]; // see [RULE11]
      block_reg <= own_next | {3{cross_next}}; // see [RULE4] see [RULE5]
      cross_reg <= cross_next;
    end
  end

  assign status = {20'h0, cross_reg, ext_reg, inrush_reg, r5_reg, r2_reg, high2_reg};
  assign second_harm_high_ph1_o = high2_reg[0];
  assign second_harm_high_ph2_o = high2_reg[1];
  assign second_harm_high_ph3_o = high2_reg[2];
  assign second_harm_restraint_ph1_o = r2_reg[0];
  assign second_harm_restraint_ph2_o = r2_reg[1];
  assign second_harm_restraint_ph3_o = r2_reg[2];
  assign second_harm_restraint_any_o = r2_any_reg;
  assign fifth_harm_restraint_ph1_o = r5_reg[0];
  assign fifth_harm_restraint_ph2_o = r5_reg[1];
  assign fifth_harm_restraint_ph3_o = r5_reg[2];
  assign fifth_harm_restraint_any_o = r5_any_reg;
  assign phase_block_ph1_o = block_reg[0];
  assign phase_block_ph2_o = block_reg[1];
  assign phase_block_ph3_o = block_reg[2];
  assign cross_block_active_o = cross_reg;
  assign inrush_condition_o = inrush_reg;
  assign ext_fault_condition_o = ext_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_harm2_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE1]
    raw[0] |=> high2_reg[0]) else $error("second harmonic flag missed");
  a_harm5_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE2]
    raw[4] |=> r5_reg[1]) else $error("fifth harmonic flag missed");
  a_drop_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE3]
    (!raw[0] && armed_reg[0]) |=> high2_reg[0] [*8]) else $error("drop extension lost");
  a_restr2_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE15]
    r2_reg[0] |-> $past(inrush_reg || ext_reg)) else $error("restraint without condition");
  a_any2_or: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE9]
    r2_any_reg == (|r2_reg)) else $error("combined second flag wrong");
  a_any5_or: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE11]
    r5_any_reg == (|r5_reg)) else $error("combined fifth flag wrong");
  a_cross_all: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE5]
    cross_reg |-> (block_reg == 3'h7)) else $error("cross blocking not on all phases");
  a_own_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE4]
    !cross_reg |-> (block_reg == (r2_reg | r5_reg))) else $error("foreign phase blocked");
  a_cross_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE6]
    (xcnt_reg >= xlimit_ticks) |=> !cross_reg) else $error("cross blocking overran");
  a_inrush_rearm: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE19]
    !inrush_qual |=> (inrush_reg && inrush_cnt_reg == 19'h0)) else $error("inrush not rearmed");
  a_ratio_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see [RULE12]
    ratio2_reg >= `HRD_RATIO_MIN && ratio2_reg <= `HRD_RATIO_MAX) else $error("ratio range");

endmodule : hrd_restraint

// ==== verification/hrd_fourier_model.sv ====
// fourier source and trip side model facing the restraint decision
`timescale 1ns/10ps

module hrd_fourier_model #(
  parameter int AMP_W = 16,
  parameter int FUND_AMP = 1000
) (
  // clock
  input wire logic sys_clk_i,
  // blocking from the restraint decision
  input wire logic [2:0] phase_block_i,
  // harmonic amplitudes per phase
  output logic [AMP_W-1:0] fund_o [3],
  output logic [AMP_W-1:0] h2_o [3],
  output logic [AMP_W-1:0] h5_o [3],
  // trip requests; differential current taken as high on every phase
  output logic [2:0] trip_req_o
);
  logic [AMP_W-1:0] h2_reg [3];
  logic [AMP_W-1:0] h5_reg [3];

  // amplitudes move on the next edge, like a registered analysis stage
  task automatic set_phase(input int ph, input int a2, input int a5);
    h2_reg[ph] <= AMP_W'(a2);
    h5_reg[ph] <= AMP_W'(a5);
  endtask : set_phase

  initial begin
    for (int i = 0; i < 3; i++) begin
      h2_reg[i] = '0;
      h5_reg[i] = '0;
      fund_o[i] = AMP_W'(FUND_AMP);
      h2_o[i] = '0;
      h5_o[i] = '0;
    end
  end

  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      fund_o[i] <= AMP_W'(FUND_AMP);
      h2_o[i] <= h2_reg[i];
      h5_o[i] <= h5_reg[i];
    end
  end

  assign trip_req_o = ~phase_block_i;
endmodule : hrd_fourier_model

// ==== verification/testbench.sv ====
// self-checking bench for the harmonic restraint decision
`timescale 1ns/10ps
`include "hrd_defines.svh"

module testbench;
  // short tick and inrush count keep the run far below real time
  localparam int INR_TICKS = 2000;
  localparam int TICK = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] rated = 16'h03E8;
  logic [15:0] s1 [3];
  logic [15:0] s2 [3];
  logic [7:0] ang [3];
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [31:0] rdata;
  wire [15:0] fund [3];
  wire [15:0] h2 [3];
  wire [15:0] h5 [3];
  wire [2:0] hi2, r2, r5, blk, trip;
  wire r2any, r5any, xact, inr, ext;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  hrd_restraint #(.TICK_CYC(TICK), .INRUSH50_TICKS(INR_TICKS),
    .INRUSH60_TICKS(INR_TICKS)) i_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn),
    .fundamental_amp_ph1_i(fund[0]), .fundamental_amp_ph2_i(fund[1]),
    .fundamental_amp_ph3_i(fund[2]),
    .second_harm_amp_ph1_i(h2[0]), .second_harm_amp_ph2_i(h2[1]),
    .second_harm_amp_ph3_i(h2[2]),
    .fifth_harm_amp_ph1_i(h5[0]), .fifth_harm_amp_ph2_i(h5[1]), .fifth_harm_amp_ph3_i(h5[2]),
    .rated_current_i(rated),
    .side1_mag_ph1_i(s1[0]), .side1_mag_ph2_i(s1[1]), .side1_mag_ph3_i(s1[2]),
    .side2_mag_ph1_i(s2[0]), .side2_mag_ph2_i(s2[1]), .side2_mag_ph3_i(s2[2]),
    .angle_diff_ph1_i(ang[0]), .angle_diff_ph2_i(ang[1]), .angle_diff_ph3_i(ang[2]),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .second_harm_high_ph1_o(hi2[0]), .second_harm_high_ph2_o(hi2[1]),
    .second_harm_high_ph3_o(hi2[2]),
    .second_harm_restraint_ph1_o(r2[0]), .second_harm_restraint_ph2_o(r2[1]),
    .second_harm_restraint_ph3_o(r2[2]), .second_harm_restraint_any_o(r2any),
    .fifth_harm_restraint_ph1_o(r5[0]), .fifth_harm_restraint_ph2_o(r5[1]),
    .fifth_harm_restraint_ph3_o(r5[2]), .fifth_harm_restraint_any_o(r5any),
    .phase_block_ph1_o(blk[0]), .phase_block_ph2_o(blk[1]), .phase_block_ph3_o(blk[2]),
    .cross_block_active_o(xact), .inrush_condition_o(inr), .ext_fault_condition_o(ext)
  );

  hrd_fourier_model i_src (
    .sys_clk_i(sys_clk), .phase_block_i(blk),
    .fund_o(fund), .h2_o(h2), .h5_o(h5), .trip_req_o(trip)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  task automatic put(input int ph, input int a2, input int a5);
    @(posedge sys_clk);
    i_src.set_phase(ph, a2, a5);
    tick(5);
  endtask : put

  task automatic set_side(input logic [7:0] a, input logic [15:0] m);
    @(posedge sys_clk);
    ang[0] <= a;
    s2[0] <= m;
    tick(5);
  endtask : set_side

  task automatic set_all(input logic [15:0] m);
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      s1[i] <= m;
      s2[i] <= m;
    end
  endtask : set_all

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(`HRD_CTRL_OFS, 32'h0000_0001);
    rd_chk(`HRD_RATIO_OFS, 32'h0000_190F);
    rd_chk(`HRD_XLIMIT_OFS, 32'h0000_1388);
    wr_reg(`HRD_RATIO_OFS, 32'h0000_3F02);
    rd_chk(`HRD_RATIO_OFS, 32'h0000_3205);
    wr_reg(`HRD_CTRL_OFS, 32'h0000_0003);
    rd_chk(`HRD_CTRL_OFS, 32'h0000_0003);
    rd_chk(8'h10, 32'h0);
    wr_reg(`HRD_RATIO_OFS, 32'h0000_190F);
    wr_reg(`HRD_CTRL_OFS, 32'h0000_0001);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ratio();
    put(0, 150, 0);
    chk(32'(hi2), 32'h0);
    put(0, 151, 0);
    chk(32'(hi2), 32'h1);
    chk(32'(r2), 32'h1);
    chk(32'(r2any), 32'h1);
    chk(32'({xact, blk, trip}), 32'h78);
    rd_chk(`HRD_STATUS_OFS, 32'h0000_0A09);
    put(0, 0, 0);
    chk(32'({hi2, r2any}), 32'h0);
    put(1, 0, 250);
    chk(32'(r5), 32'h0);
    put(1, 0, 251);
    chk(32'({r5, hi2}), 32'h10);
    chk(32'(r5any), 32'h1);
    put(1, 0, 0);
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_cross_off();
    wr_reg(`HRD_CTRL_OFS, 32'h0);
    put(2, 0, 300);
    chk(32'({xact, blk, trip}), 32'h23);
    put(2, 0, 0);
    wr_reg(`HRD_CTRL_OFS, 32'h0000_0001);
    $display("test cross off done");
  endtask : t_cross_off

  // pick-up 2501 / 2084 ticks, drop-off 1500 / 1250 ticks, one tick every two cycles
  task automatic t_hold();
    put(1, 0, 300);
    tick(4985);
    put(1, 0, 0);
    chk(32'(r5), 32'h0);
    put(1, 0, 300);
    tick(5100);
    put(1, 0, 0);
    chk(32'(r5), 32'h2);
    tick(2990);
    chk(32'(r5), 32'h2);
    tick(20);
    chk(32'(r5), 32'h0);
    wr_reg(`HRD_CTRL_OFS, 32'h0000_0003);
    put(1, 0, 300);
    tick(4250);
    put(1, 0, 0);
    tick(2470);
    chk(32'(r5), 32'h2);
    tick(40);
    chk(32'(r5), 32'h0);
    wr_reg(`HRD_CTRL_OFS, 32'h0000_0001);
    $display("test hold done");
  endtask : t_hold

  // a limit of 100 ms is 10000 ticks
  task automatic t_xlimit();
    wr_reg(`HRD_XLIMIT_OFS, 32'h0000_0001);
    rd_chk(`HRD_XLIMIT_OFS, 32'h0000_0064);
    put(2, 0, 300);
    chk(32'({xact, blk, trip}), 32'h78);
    tick(19980);
    chk(32'(xact), 32'h1);
    tick(30);
    chk(32'({xact, blk, trip}), 32'h23);
    put(2, 0, 0);
    $display("test cross limit done");
  endtask : t_xlimit

  task automatic t_ext();
    set_side(8'h4B, 16'h01F4);
    chk(32'(ext), 32'h1);
    set_side(8'h4A, 16'h01F4);
    chk(32'(ext), 32'h0);
    set_side(8'h4B, 16'h0064);
    chk(32'(ext), 32'h0);
    set_side(8'h4B, 16'h0065);
    chk(32'(ext), 32'h1);
    set_side(8'h00, 16'h01F4);
    $display("test ext fault done");
  endtask : t_ext

  task automatic t_inrush();
    set_all(16'h0000);
    tick(5);
    chk(32'(inr), 32'h1);
    set_all(16'h01F4);
    n = 0;
    while (inr !== 1'b0 && n < 50000) begin
      tick(1);
      n++;
    end
    chk(32'(n >= INR_TICKS * TICK && n <= (INR_TICKS + 2) * TICK + 20), 32'h1);
    put(0, 200, 0);
    chk(32'(inr), 32'h1);
    put(0, 0, 0);
    $display("test inrush done");
  endtask : t_inrush

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      results();
    end
  end

  initial begin
    for (int i = 0; i < 3; i++) begin
      s1[i] = 16'h01F4;
      s2[i] = 16'h01F4;
      ang[i] = 8'h00;
    end
    repeat (16) @(posedge sys_clk);
    #1;
    chk(32'(inr), 32'h1);
    @(posedge sys_clk);
    resetn <= 1'b1;
    tick(3);
    t_regs();
    t_ratio();
    t_cross_off();
    t_hold();
    t_xlimit();
    t_ext();
    t_inrush();
    results();
  end
endmodule : testbench
